// *** rhc_regs.vh ***
// register map, command codes and timing constants of the rheostat control logic
`ifndef RHC_REGS_VH
`define RHC_REGS_VH
`define RHC_CTRL_W 10
`define RHC_CTRL_RST 4'h0
`define RHC_BIT_PGM_EN 0
`define RHC_BIT_WUNLOCK 1
`define RHC_BIT_CAL_DIS 2
`define RHC_BIT_STORE_OK 3
`define RHC_CMD_NOP 4'h0
`define RHC_CMD_WR_WIPER 4'h1
`define RHC_CMD_RD_WIPER 4'h2
`define RHC_CMD_STORE 4'h3
`define RHC_CMD_SW_RESET 4'h4
`define RHC_CMD_RD_MEM 4'h5
`define RHC_CMD_RD_LAST 4'h6
`define RHC_CMD_WR_CTRL 4'h7
`define RHC_CMD_RD_CTRL 4'h8
`define RHC_CMD_SHDN 4'h9
`define RHC_MEM_LOCS 6'h32
`define RHC_MIDSCALE 10'h200
`define RHC_I2C_ADDR 7'h2C
// internal store cycle: 3000 ns of the 10 ns clock; longer than one address byte
// at the bus rate, so a poll sent right after a store is really refused
`define RHC_STORE_CYC 16'h012C
`endif

// *** rhc_ctrl.v ***
// I2C command interpreter, control register and one-time wiper memory of the rheostat
// ----------------------------------------
// ----------------------------------------
module rhc_ctrl (
	input wire sys_clk_i,
	input wire rst_b_i,
	input wire clk_en_i,
	input wire reset_pin_b_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_oe_b_o,
	output reg [9:0] wiper_o,
	output reg shutdown_o,
	output reg cal_disable_o,
	output reg busy_o
);
`include "rhc_regs.vh"

localparam ST_IDLE = 3'h0;
localparam ST_SHIFT = 3'h1;
localparam ST_ACK = 3'h2;
localparam ST_TX = 3'h3;
localparam ST_TXACK = 3'h4;
localparam ST_SKIP = 3'h5;

// ----------------------------------------
// pin synchronisers and edge detect
// ----------------------------------------
reg [1:0] scl_sy_ff, sda_sy_ff, rst_sy_ff;
reg scl_d_ff, sda_d_ff, rstp_d_ff;
always @(posedge sys_clk_i) begin
	if (!rst_b_i) begin
		scl_sy_ff <= 2'h3;
		sda_sy_ff <= 2'h3;
		rst_sy_ff <= 2'h3;
		scl_d_ff <= 1'b1;
		sda_d_ff <= 1'b1;
		rstp_d_ff <= 1'b1;
	end else if (clk_en_i) begin
		scl_sy_ff <= {scl_sy_ff[0], scl_i};
		sda_sy_ff <= {sda_sy_ff[0], sda_i};
		rst_sy_ff <= {rst_sy_ff[0], reset_pin_b_i};
		scl_d_ff <= scl_sy_ff[1];
		sda_d_ff <= sda_sy_ff[1];
		rstp_d_ff <= rst_sy_ff[1];
	end
end
wire scl_s = scl_sy_ff[1];
wire sda_s = sda_sy_ff[1];
wire scl_rise = scl_s & ~scl_d_ff;
wire scl_fall = ~scl_s & scl_d_ff;
wire start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
wire stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
wire hw_reset = ~rst_sy_ff[1] & rstp_d_ff; // act once on the falling edge of the pin

// ----------------------------------------
// state
// ----------------------------------------
reg [9:0] mem_ff [1:50]; // one_time_wiper_memory
reg [5:0] last_loc_ff;
reg [3:0] ctrl_ff;
reg [2:0] st_ff;
reg [3:0] bit_ff;
reg [1:0] byte_ff;
reg [7:0] sh_ff;
reg [15:0] word_ff;
reg [15:0] tx_ff;
reg [15:0] rd_ff;
reg rw_ff;
reg [15:0] busy_cnt_ff;
reg [9:0] wiper_setting_register_ff;
wire [9:0] last_val = (last_loc_ff == 6'h0) ? `RHC_MIDSCALE : mem_ff[last_loc_ff];
wire [9:0] ctrl_rd = {6'h00, ctrl_ff};
wire [3:0] cmd = word_ff[13:10];
wire [5:0] mem_addr = word_ff[5:0];
wire busy = (busy_cnt_ff != 16'h0000);

// ----------------------------------------
// serial engine and command execution
// ----------------------------------------
always @(posedge sys_clk_i) begin
	if (!rst_b_i) begin
		st_ff <= ST_IDLE;
		bit_ff <= 4'h0;
		byte_ff <= 2'h0;
		sh_ff <= 8'h00;
		word_ff <= 16'h0000;
		tx_ff <= 16'h0000;
		rd_ff <= 16'h0000;
		rw_ff <= 1'b0;
		sda_oe_b_o <= 1'b1;
		ctrl_ff <= `RHC_CTRL_RST;
		last_loc_ff <= 6'h00;
		busy_cnt_ff <= 16'h0000;
		wiper_setting_register_ff <= `RHC_MIDSCALE;
		wiper_o <= `RHC_MIDSCALE;
		shutdown_o <= 1'b0;
		cal_disable_o <= 1'b0;
		busy_o <= 1'b0;
	end else if (clk_en_i) begin
		wiper_o <= wiper_setting_register_ff;
		cal_disable_o <= ctrl_ff[`RHC_BIT_CAL_DIS];
		busy_o <= busy;
		if (busy)
			busy_cnt_ff <= busy_cnt_ff - 16'h0001;
		if (hw_reset) begin
			wiper_setting_register_ff <= last_val;
			shutdown_o <= 1'b0;
		end
		if (start_c) begin
			st_ff <= ST_SHIFT;
			bit_ff <= 4'h0;
			byte_ff <= 2'h0;
			sda_oe_b_o <= 1'b1;
		end else if (stop_c) begin
			st_ff <= ST_IDLE;
			sda_oe_b_o <= 1'b1;
		end else begin
			case (st_ff)
				ST_SHIFT: begin
					if (scl_rise) begin
						sh_ff <= {sh_ff[6:0], sda_s};
						bit_ff <= bit_ff + 4'h1;
					end else if (scl_fall && bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						if (byte_ff == 2'h0) begin
							// address byte; silent while the store cycle runs
							if (sh_ff[7:1] == `RHC_I2C_ADDR && !busy) begin
								sda_oe_b_o <= 1'b0;
								rw_ff <= sh_ff[0];
								tx_ff <= rd_ff;
								st_ff <= ST_ACK;
							end else
								st_ff <= ST_SKIP;
						end else if (busy) begin
							// data bytes during a store cycle are refused like the address
							st_ff <= ST_SKIP;
						end else begin
							sda_oe_b_o <= 1'b0;
							st_ff <= ST_ACK;
							if (byte_ff == 2'h1)
								word_ff[15:8] <= sh_ff;
							else
								word_ff[7:0] <= sh_ff;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe_b_o <= 1'b1;
						if (rw_ff) begin
							sda_oe_b_o <= tx_ff[15];
							st_ff <= ST_TX;
						end else
							st_ff <= ST_SHIFT;
						byte_ff <= (byte_ff == 2'h2) ? 2'h1 : byte_ff + 2'h1;
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						bit_ff <= bit_ff + 4'h1;
						tx_ff <= {tx_ff[14:0], 1'b0};
						if (bit_ff == 4'h7) begin
							sda_oe_b_o <= 1'b1;
							st_ff <= ST_TXACK;
						end else
							sda_oe_b_o <= tx_ff[14];
					end
				end
				ST_TXACK: begin
					// master ack continues, nack stops
					if (scl_rise) begin
						bit_ff <= 4'h0;
						st_ff <= sda_s ? ST_SKIP : ST_ACK;
					end
				end
				default: st_ff <= st_ff;
			endcase
		end
		// execute once the second data byte is acked; all commands run in shutdown
		if (st_ff == ST_ACK && scl_fall && !rw_ff && byte_ff == 2'h2) begin
			case (cmd)
				`RHC_CMD_WR_WIPER:
					if (ctrl_ff[`RHC_BIT_WUNLOCK])
						wiper_setting_register_ff <= word_ff[9:0];
				`RHC_CMD_RD_WIPER: rd_ff <= {6'h00, wiper_setting_register_ff};
				`RHC_CMD_STORE: begin
					// store fails when disabled or full
					if (ctrl_ff[`RHC_BIT_PGM_EN] && last_loc_ff != `RHC_MEM_LOCS) begin
						mem_ff[last_loc_ff + 6'h01] <= wiper_setting_register_ff;
						last_loc_ff <= last_loc_ff + 6'h01;
						ctrl_ff[`RHC_BIT_STORE_OK] <= 1'b1;
						busy_cnt_ff <= `RHC_STORE_CYC;
					end else
						ctrl_ff[`RHC_BIT_STORE_OK] <= 1'b0;
				end
				`RHC_CMD_SW_RESET: begin
					wiper_setting_register_ff <= last_val;
					shutdown_o <= 1'b0;
				end
				`RHC_CMD_RD_MEM:
					// reserved or unprogrammed location reads zero
					if (mem_addr != 6'h00 && mem_addr <= last_loc_ff)
						rd_ff <= {6'h00, mem_ff[mem_addr]};
					else
						rd_ff <= 16'h0000;
				`RHC_CMD_RD_LAST: rd_ff <= {10'h000, last_loc_ff};
				`RHC_CMD_WR_CTRL: ctrl_ff[2:0] <= word_ff[2:0];
				`RHC_CMD_RD_CTRL: rd_ff <= {6'h00, ctrl_rd};
				`RHC_CMD_SHDN: shutdown_o <= word_ff[0];
				default: rd_ff <= rd_ff;
			endcase
		end
	end
end

endmodule

// *** rhc_i2c_host.sv ***
// bus controller model that drives the rheostat link
`include "rhc_regs.vh"
module rhc_i2c_host (
	input wire logic sda_i,
	output logic scl_o = 1'b1,
	output logic sda_o = 1'b1
);
	timeunit 1ns;
	timeprecision 100ps;
	int n_nack = 0;
	int n_giveup = 0;
	// one bit: data moves in the low phase and is read midway through the high phase
	task automatic bitx(input logic b, output logic r);
		#20 sda_o = b;
		#60 scl_o = 1'b1;
		#40 r = sda_i;
		#40 scl_o = 1'b0;
	endtask
	task automatic byte_x(input logic [7:0] d, input logic m, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
		bitx(m, ack);
		ack = !ack;
	endtask
	task automatic stop();
		#20 sda_o = 1'b0;
		#60 scl_o = 1'b1;
		#80 sda_o = 1'b1;
		#80;
	endtask
	// address phase, tried again while the device is busy storing
	task automatic open(input logic rd);
		logic [7:0] x;
		logic a;
		for (int k = 0; k < 200; k++) begin
			#80 sda_o = 1'b0;
			#80 scl_o = 1'b0;
			byte_x({`RHC_I2C_ADDR, rd}, 1'b1, x, a);
			if (a) break;
			n_nack++;
			stop();
		end
		// a poll that never got an answer is counted, not hidden
		if (!a) n_giveup++;
	endtask
endmodule

// *** rhc_ctrl_assertions.sv ***
// port checks of the rheostat control logic
`include "rhc_regs.vh"
module rhc_ctrl_assertions (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic reset_pin_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_oe_b_o,
	input wire logic [9:0] wiper_o,
	input wire logic shutdown_o,
	input wire logic cal_disable_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	// reset must itself be watched, so this one is never disabled
	chk_reset_vals: assert property (@(posedge sys_clk_i) disable iff (1'b0)
		!rst_b_i && clk_en_i |=> wiper_o == `RHC_MIDSCALE && sda_oe_b_o && !shutdown_o && !busy_o && !cal_disable_o)
		else $error("reset values wrong");
	chk_busy_hold: assert property ($rose(busy_o) |-> busy_o[*8]) else $error("store cycle too short");
	chk_busy_len: assert property ($rose(busy_o) |-> ##[295:305] !busy_o) else $error("store cycle length");
	chk_poll_nack: assert property (busy_o && $past(busy_o, 4) |-> sda_oe_b_o) else $error("ack while busy");
	chk_freeze_hold: assert property (!$past(clk_en_i) && $past(rst_b_i) |-> $stable(wiper_o) && $stable(busy_o))
		else $error("state moved while frozen");
	chk_pin_exit: assert property ($fell(reset_pin_b_i) |-> ##[1:8] !shutdown_o) else $error("pin kept shutdown");
	chk_sda_scl_low: assert property ($changed(sda_oe_b_o) |-> !scl_i) else $error("sda moved, scl high");
	chk_shdn_cmd: assert property ($rose(shutdown_o) |-> !scl_i) else $error("shutdown off frame");
	cover property ($rose(busy_o));
	cover property ($rose(shutdown_o));
	cover property ($fell(reset_pin_b_i));
endmodule
bind rhc_ctrl rhc_ctrl_assertions chk (.*);

// *** rhc_ctrl_test.sv ***
// self-checking bench: the rheostat control against a queue model
module rhc_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_i = 0, rst_b_i = 0, clk_en_i = 1, reset_pin_b_i = 1, scl_i, sda_o, a, msd = 0;
	logic sda_oe_b_o, shutdown_o, cal_disable_o, busy_o;
	logic [9:0] wiper_o, mw = 10'h200;
	logic [15:0] mrd, w;
	logic [7:0] x;
	int n_errors = 0, n_tests = 0, ctl = 0;
	int mem[$];
	logic [13:0] seq[$] = '{'h2000, 'h0400, 'h1C07, 'h2000, 'h0400, 'h0800, 'h0C00, 'h1800, 'h1401,
		'h1780, 'h2000, 'h0400, 'h2401, 'h0400, 'h1000, 'h2401, 'h2400, 'h1C02, 'h0C00, 'h2000, 'h1C03};
	// open-drain line with pull-up
	wire sda_i = sda_o & sda_oe_b_o;
	always #5 sys_clk_i = ~sys_clk_i;
	rhc_ctrl DUT (.*);
	rhc_i2c_host host (.sda_i(sda_i), .scl_o(scl_i), .sda_o(sda_o));
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
		n_tests++;
		if (v !== e) begin
			$display("[FAIL] %s expected %h seen %h", s, e, v);
			n_errors++;
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one command frame, the model update, then a readback for read commands
	task automatic cmd(input logic [3:0] c, input logic [9:0] d);
		host.open(1'b0);
		host.byte_x({2'b00, c, d[9:8]}, 1'b1, x, a);
		host.byte_x(d[7:0], 1'b1, x, a);
		host.stop();
		case (c)
			1: if (ctl[1]) mw = d;
			2: mrd = mw;
			3: if (ctl[0] && mem.size() < 50) begin
				mem.push_back(mw);
				ctl |= 8;
			end else ctl &= 7;
			4: mw = mem.size() ? mem[$] : 10'h200;
			5: mrd = (d[5:0] && d[5:0] <= mem.size()) ? mem[d[5:0] - 1] : 0;
			6: mrd = mem.size();
			7: ctl = ctl & 8 | d & 7;
			8: mrd = ctl;
			9: msd = d[0];
		endcase
		if (c == 4) msd = 0;
		if (c == 3) chk("busy", ctl[3], busy_o);
		repeat (8) @(negedge sys_clk_i);
		chk("wiper", mw, wiper_o);
		chk("shutdown", msd, shutdown_o);
		chk("cal_disable", ctl[2], cal_disable_o);
		if (c inside {2, 5, 6, 8}) begin
			host.open(1'b1);
			host.byte_x(8'hFF, 1'b0, w[15:8], a);
			host.byte_x(8'hFF, 1'b1, w[7:0], a);
			host.stop();
			chk("readback", mrd, w);
		end
	endtask
	initial begin
		void'($urandom(32'hCAB8FA85));
		repeat (16) @(negedge sys_clk_i);
		rst_b_i = 1;
		repeat (4) @(negedge sys_clk_i);
		foreach (seq[i]) cmd(seq[i][13:10], seq[i][9:0] ^ (seq[i][13:10] == 1 ? $urandom : 0));
		chk("polled", 1, host.n_nack > 0);
		// move the wiper off the stored value so that the pin reload is visible
		cmd(4'h1, 10'($urandom));
		cmd(9, 1);
		@(negedge sys_clk_i) reset_pin_b_i = 0;
		repeat (4) @(negedge sys_clk_i);
		reset_pin_b_i = 1;
		clk_en_i = 0;
		repeat (20) @(negedge sys_clk_i);
		clk_en_i = 1;
		repeat (12) @(negedge sys_clk_i);
		chk("pin reload", mem[$], wiper_o);
		chk("pin exit", 0, shutdown_o);
		msd = 0;
		mw = mem[$];
		repeat (50) cmd(3, 0);
		cmd(8, 0);
		cmd(6, 0);
		chk("poll give-ups", 0, host.n_giveup);
		// second release of the system reset in mid-run: all state except the mem_ff contents back to defaults
		@(negedge sys_clk_i) rst_b_i = 0;
		repeat (2) @(negedge sys_clk_i);
		rst_b_i = 1;
		mem.delete();
		ctl = 0;
		mw = 10'h200;
		msd = 0;
		repeat (4) @(negedge sys_clk_i);
		chk("reset wiper", mw, wiper_o);
		cmd(6, 0);
		cmd(8, 0);
		stop_test();
	end
	initial begin
		#900us;
		n_errors++;
		stop_test();
	end
endmodule
